/* common/scp_consts.vh */
/*
 Constants for the secondary safe-channel position bank: register offsets,
 status byte layout, checksum parameters and the remote window limits.
 Assumes inclusion by bare name from the design files.
*/
`ifndef SCP_CONSTS_VH
`define SCP_CONSTS_VH

// ============================================================
// Register offsets of the secondary channel bank
`define SCP_OFS_STATE 7'h18
`define SCP_OFS_POS4 7'h19
`define SCP_OFS_POS3 7'h1a
`define SCP_OFS_POS2 7'h1b
`define SCP_OFS_POS1 7'h1c
`define SCP_OFS_POS0 7'h1d
`define SCP_OFS_CRC_HI 7'h1e
`define SCP_OFS_CRC_LO 7'h1f

// ============================================================
// Reset values
`define SCP_RST_BYTE 8'h00
`define SCP_RST_POS 40'h00_0000_0000
`define SCP_RST_CRC 16'h0000

// ============================================================
// Channel state byte fields
`define SCP_BIT_TOGGLE 7
`define SCP_BIT_TESTED 6
`define SCP_BIT_FAULT 5
`define SCP_FIX_MSB 4
`define SCP_FIX_LSB 0
`define SCP_FIX_PATTERN 5'h1c

// ============================================================
// Checksum: reversed-reciprocal C86C is normal form 90D9
`define SCP_CRC_POLY 16'h90d9
`define SCP_CRC_INIT 16'h0000
`define SCP_CRC_XOR 16'h00ff
`define SCP_CRC_BYTES 3'h6
`define SCP_CRC_LAST 3'h5

// ============================================================
// Remote encoder window and its local mirror status bytes
`define SCP_RMT_LO 7'h40
`define SCP_RMT_HI 7'h7f
`define SCP_MIR_LO 7'h60
`define SCP_MIR_HI 7'h67

// ============================================================
// Host interface codes
`define SCP_IF_DRIVE 2'h0
`define SCP_IF_SAFE1 2'h1
`define SCP_IF_SAFE2 2'h2

`endif

/* design/scp_crc_byte.v */
/*
 One byte step of the 16-bit checksum, most significant bit first,
 no reflection of data or remainder.
 Assumes the caller holds the running remainder in a register.
*/
`timescale 1ns/1ps

module scp_crc_byte #(
    parameter [15:0] POLY = 16'h90d9
) (
    // Running remainder and next byte
    input wire [15:0] crc_i,
    input wire [7:0] data_i,
    // Updated remainder
    output reg [15:0] crc_o
);

    integer i;
    reg fb;

    // ============================================================
    // Shift eight bits, MSB first
    always @* begin
        crc_o = crc_i;
        fb = 1'b0;
        for (i = 7; i >= 0; i = i - 1) begin
            fb = crc_o[15] ^ data_i[i];
            crc_o = {crc_o[14:0], 1'b0};
            if (fb) begin
                crc_o = crc_o ^ POLY;
            end
        end
    end

endmodule // scp_crc_byte

/* design/scp_safe_pos2_bank.v */
/*
 Secondary safe-channel position bank: takes each frame offered while idle, checks
 its checksum byte by byte, then commits state, position and checksum
 registers together. Also gates host access to the remote encoder window.
 Assumes frames and host requests are synchronous to sys_clk_i, and that
 a short-message engine outside serves forwarded remote accesses.
*/
`timescale 1ns/1ps
`include "scp_consts.vh"

// Overview of operation
// - Forty-bit position over five byte registers
// - Position stored as bitwise complement
// - Position and checksum registers read-only, reset zero
// - CRC16 poly C86C reversed, init zero, xor 00FF
// - No reflection of data or remainder
// - Feed state byte, then position MSB down
// - Checksum high at 1Eh, low at 1Fh
// - Device verifies received checksum itself
// - Remote registers mirrored at 40h to 7Fh
// - Remote via safe1 only; mirror status via drive
// - State byte: toggle, tested, fault, fixed pattern
module scp_safe_pos2_bank (
    // Clock and reset
    input wire sys_clk_i,
    input wire rstn_i,
    // Received frame from the link
    input wire frame_valid_i,
    input wire [7:0] frame_state_i,
    input wire [39:0] frame_abs_pos_i,
    input wire [15:0] frame_crc_i,
    output wire frame_busy_o,
    // Frame results
    output reg frame_done_o,
    output reg crc_fault_o,
    output reg pattern_fault_o,
    output reg toggle_fault_o,
    // Register read port
    input wire rd_i,
    input wire [6:0] rd_addr_i,
    output reg rd_valid_o,
    output reg [7:0] rd_data_o,
    // Host access to the remote window
    input wire rmt_req_i,
    input wire [1:0] rmt_if_i,
    input wire [6:0] rmt_addr_i,
    input wire rmt_wr_i,
    input wire [7:0] rmt_wdata_i,
    output reg rmt_ack_o,
    output reg rmt_refuse_o,
    output reg [7:0] rmt_rdata_o,
    // Forward to the short-message engine
    output reg sm_req_o,
    output reg sm_local_o,
    output reg [6:0] sm_addr_o,
    output reg sm_wr_o,
    output reg [7:0] sm_wdata_o,
    input wire sm_done_i,
    input wire [7:0] sm_rdata_i
);

    // ============================================================
    // Frame checker states
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_CALC = 3'b010;
    localparam [2:0] ST_CMT = 3'b100;

    // ============================================================
    // Remote access states
    localparam [1:0] RM_IDLE = 2'b01;
    localparam [1:0] RM_WAIT = 2'b10;

    reg [2:0] st_q;
    reg [2:0] st_d;
    reg [2:0] idx_q;
    reg [15:0] crc_q;
    reg [7:0] sh_state_q;
    reg [39:0] sh_pos_q;
    reg [15:0] sh_crc_q;
    reg [7:0] secondary_channel_state_q;
    reg [39:0] secondary_safe_position_q;
    reg [15:0] secondary_position_checksum_q;
    reg last_toggle_q;
    reg seen_frame_q;
    reg [1:0] rm_q;
    reg [7:0] crc_byte;
    wire [15:0] crc_next;
    wire [15:0] crc_final;
    wire in_rmt;
    wire in_mir;
    reg rmt_allowed;

    // ============================================================
    // Byte order into the checksum
    always @* begin
        case (idx_q)
            3'h0: crc_byte = sh_state_q;
            3'h1: crc_byte = sh_pos_q[39:32];
            3'h2: crc_byte = sh_pos_q[31:24];
            3'h3: crc_byte = sh_pos_q[23:16];
            3'h4: crc_byte = sh_pos_q[15:8];
            default: crc_byte = sh_pos_q[7:0];
        endcase
    end

    // ============================================================
    // Checksum engine
    // One byte per cycle keeps the engine small; six cycles per frame
    scp_crc_byte #(
        .POLY(`SCP_CRC_POLY)
    ) u_crc (
        .crc_i(crc_q),
        .data_i(crc_byte),
        .crc_o(crc_next)
    );

    // Final XOR only on the compared value; the running remainder stays raw
    assign crc_final = crc_q ^ `SCP_CRC_XOR;

    // ============================================================
    // Frame handshake
    // A new frame arriving mid-check is dropped; the link repeats every eighth frame
    assign frame_busy_o = (st_q != ST_IDLE);

    // ============================================================
    // Frame checker sequencing
    always @* begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                if (frame_valid_i) begin
                    st_d = ST_CALC;
                end
            end
            ST_CALC: begin
                if (idx_q == `SCP_CRC_LAST) begin
                    st_d = ST_CMT;
                end
            end
            ST_CMT: begin
                st_d = ST_IDLE;
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    // ============================================================
    // Frame checker registers
    always @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            st_q <= ST_IDLE;
            idx_q <= 3'h0;
            crc_q <= `SCP_CRC_INIT;
            sh_state_q <= `SCP_RST_BYTE;
            sh_pos_q <= `SCP_RST_POS;
            sh_crc_q <= `SCP_RST_CRC;
            secondary_channel_state_q <= `SCP_RST_BYTE;
            secondary_safe_position_q <= `SCP_RST_POS;
            secondary_position_checksum_q <= `SCP_RST_CRC;
            last_toggle_q <= 1'b0;
            seen_frame_q <= 1'b0;
            frame_done_o <= 1'b0;
            crc_fault_o <= 1'b0;
            pattern_fault_o <= 1'b0;
            toggle_fault_o <= 1'b0;
        end else begin
            st_q <= st_d;
            frame_done_o <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    if (frame_valid_i) begin
                        sh_state_q <= frame_state_i;
                        // Complemented on capture so the checksum runs over stored bytes
                        sh_pos_q <= ~frame_abs_pos_i;
                        sh_crc_q <= frame_crc_i;
                        crc_q <= `SCP_CRC_INIT;
                        idx_q <= 3'h0;
                    end
                end
                ST_CALC: begin
                    crc_q <= crc_next;
                    idx_q <= idx_q + 3'h1;
                end
                ST_CMT: begin
                    // All registers move in one edge so a read never mixes frames
                    secondary_channel_state_q <= sh_state_q;
                    secondary_safe_position_q <= sh_pos_q;
                    secondary_position_checksum_q <= sh_crc_q;
                    crc_fault_o <= (crc_final != sh_crc_q);
                    pattern_fault_o <=
                        (sh_state_q[`SCP_FIX_MSB:`SCP_FIX_LSB] != `SCP_FIX_PATTERN);
                    toggle_fault_o <= seen_frame_q &&
                        (sh_state_q[`SCP_BIT_TOGGLE] == last_toggle_q);
                    last_toggle_q <= sh_state_q[`SCP_BIT_TOGGLE];
                    seen_frame_q <= 1'b1;
                    frame_done_o <= 1'b1;
                end
                default: begin
                    idx_q <= 3'h0;
                end
            endcase
        end
    end

    // ============================================================
    // Read-only register decode; writes have no path into the bank
    always @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            rd_valid_o <= 1'b0;
            rd_data_o <= `SCP_RST_BYTE;
        end else begin
            rd_valid_o <= rd_i;
            if (!rd_i) begin
                rd_data_o <= rd_data_o;
            end else if (rd_addr_i == `SCP_OFS_STATE) begin
                rd_data_o <= secondary_channel_state_q;
            end else if (rd_addr_i == `SCP_OFS_POS4) begin
                rd_data_o <= secondary_safe_position_q[39:32];
            end else if (rd_addr_i == `SCP_OFS_POS3) begin
                rd_data_o <= secondary_safe_position_q[31:24];
            end else if (rd_addr_i == `SCP_OFS_POS2) begin
                rd_data_o <= secondary_safe_position_q[23:16];
            end else if (rd_addr_i == `SCP_OFS_POS1) begin
                rd_data_o <= secondary_safe_position_q[15:8];
            end else if (rd_addr_i == `SCP_OFS_POS0) begin
                rd_data_o <= secondary_safe_position_q[7:0];
            end else if (rd_addr_i == `SCP_OFS_CRC_HI) begin
                rd_data_o <= secondary_position_checksum_q[15:8];
            end else if (rd_addr_i == `SCP_OFS_CRC_LO) begin
                rd_data_o <= secondary_position_checksum_q[7:0];
            end else begin
                rd_data_o <= `SCP_RST_BYTE;
            end
        end
    end

    // ============================================================
    // Remote window access gating
    assign in_rmt = (rmt_addr_i >= `SCP_RMT_LO) && (rmt_addr_i <= `SCP_RMT_HI);
    assign in_mir = (rmt_addr_i >= `SCP_MIR_LO) && (rmt_addr_i <= `SCP_MIR_HI);

    // Mirror bytes are local copies, so only the drive side may touch them
    always @* begin
        if (!in_rmt) begin
            rmt_allowed = 1'b0;
        end else if (in_mir) begin
            rmt_allowed = (rmt_if_i == `SCP_IF_DRIVE);
        end else begin
            rmt_allowed = (rmt_if_i == `SCP_IF_SAFE1);
        end
    end

    // ============================================================
    // Remote access sequencing
    always @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            rm_q <= RM_IDLE;
            rmt_ack_o <= 1'b0;
            rmt_refuse_o <= 1'b0;
            rmt_rdata_o <= `SCP_RST_BYTE;
            sm_req_o <= 1'b0;
            sm_local_o <= 1'b0;
            sm_addr_o <= 7'h00;
            sm_wr_o <= 1'b0;
            sm_wdata_o <= `SCP_RST_BYTE;
        end else begin
            rmt_ack_o <= 1'b0;
            rmt_refuse_o <= 1'b0;
            sm_req_o <= 1'b0;
            case (rm_q)
                RM_IDLE: begin
                    if (rmt_req_i && rmt_allowed) begin
                        sm_req_o <= 1'b1;
                        sm_local_o <= in_mir;
                        sm_addr_o <= rmt_addr_i;
                        sm_wr_o <= rmt_wr_i;
                        sm_wdata_o <= rmt_wdata_i;
                        rm_q <= RM_WAIT;
                    end else if (rmt_req_i) begin
                        rmt_refuse_o <= 1'b1;
                    end
                end
                RM_WAIT: begin
                    // Only one remote byte may be outstanding at a time
                    if (rmt_req_i) begin
                        rmt_refuse_o <= 1'b1;
                    end
                    if (sm_done_i) begin
                        rmt_ack_o <= 1'b1;
                        rmt_rdata_o <= sm_rdata_i;
                        rm_q <= RM_IDLE;
                    end
                end
                default: begin
                    rm_q <= RM_IDLE;
                end
            endcase
        end
    end

endmodule // scp_safe_pos2_bank

/* sim/scp_bank_sva.sv */
/* Checker for the secondary safe position bank, on its ports only.
   Assumes one clock and a synchronous active low reset. */
`timescale 1ns/1ps
`include "scp_consts.vh"
module scp_bank_sva (
    // Clock and reset
    input wire sys_clk_i,
    input wire rstn_i,
    // Frame side
    input wire frame_valid_i,
    input wire [39:0] frame_abs_pos_i,
    input wire [15:0] frame_crc_i,
    input wire frame_busy_o,
    input wire frame_done_o,
    // Read port
    input wire rd_i,
    input wire [6:0] rd_addr_i,
    input wire rd_valid_o,
    input wire [7:0] rd_data_o,
    // Remote window
    input wire rmt_req_i,
    input wire [1:0] rmt_if_i,
    input wire [6:0] rmt_addr_i,
    input wire rmt_ack_o,
    input wire rmt_refuse_o,
    input wire [7:0] rmt_rdata_o,
    input wire sm_req_o,
    input wire sm_local_o,
    input wire [6:0] sm_addr_o,
    input wire sm_done_i,
    input wire [7:0] sm_rdata_i
);
    // ====================
    // Shadow of taken and committed frames
    reg [39:0] cap_pos_q;
    reg [39:0] com_pos_q;
    reg [15:0] cap_crc_q;
    reg [15:0] com_crc_q;
    wire take = frame_valid_i && !frame_busy_o;
    wire mir = rmt_addr_i >= `SCP_MIR_LO && rmt_addr_i <= `SCP_MIR_HI;
    wire ok = rmt_addr_i >= `SCP_RMT_LO && (mir ? rmt_if_i == `SCP_IF_DRIVE
        : rmt_if_i == `SCP_IF_SAFE1);
    always @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            com_pos_q <= `SCP_RST_POS;
            com_crc_q <= `SCP_RST_CRC;
        end else begin
            if (take) begin
                cap_pos_q <= ~frame_abs_pos_i;
                cap_crc_q <= frame_crc_i;
            end
            // Committed copy lags one edge, matching the read latency
            if (frame_done_o) begin
                com_pos_q <= cap_pos_q;
                com_crc_q <= cap_crc_q;
            end
        end
    end
    // ====================
    // Properties
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    a_read_answer: assert property (rd_i |=> rd_valid_o)
        else $error("read not answered");
    a_frame_timing: assert property (
        take |=> frame_busy_o [*7] ##1 (frame_done_o && !frame_busy_o))
        else $error("frame commit timing wrong");
    a_done_cause: assert property (frame_done_o |-> $past(frame_busy_o))
        else $error("commit without a frame");
    a_crc_low_read: assert property (
        rd_valid_o && $past(rd_addr_i) == `SCP_OFS_CRC_LO |-> rd_data_o == com_crc_q[7:0])
        else $error("checksum low byte wrong");
    a_crc_high_read: assert property (
        rd_valid_o && $past(rd_addr_i) == `SCP_OFS_CRC_HI |-> rd_data_o == com_crc_q[15:8])
        else $error("checksum high byte wrong");
    a_pos_low_read: assert property (
        rd_valid_o && $past(rd_addr_i) == `SCP_OFS_POS0 |-> rd_data_o == com_pos_q[7:0])
        else $error("position low byte wrong");
    a_pos_top_read: assert property (
        rd_valid_o && $past(rd_addr_i) == `SCP_OFS_POS4 |-> rd_data_o == com_pos_q[39:32])
        else $error("position top byte wrong");
    a_refuse_bad: assert property (rmt_req_i && !ok |=> rmt_refuse_o && !sm_req_o)
        else $error("illegal remote access not refused");
    a_forward_fields: assert property (
        sm_req_o |-> $past(rmt_req_i) && sm_addr_o == $past(rmt_addr_i)
            && sm_local_o == (sm_addr_o >= `SCP_MIR_LO && sm_addr_o <= `SCP_MIR_HI))
        else $error("forwarded request wrong");
    a_ack_data: assert property (
        sm_done_i |=> rmt_ack_o && rmt_rdata_o == $past(sm_rdata_i))
        else $error("remote answer wrong");
    a_reset_quiet: assert property (
        disable iff (1'b0)
        !rstn_i |=> !frame_done_o && !rd_valid_o && !sm_req_o && !rmt_ack_o)
        else $error("output active in reset");
endmodule // scp_bank_sva

bind scp_safe_pos2_bank scp_bank_sva chk_u (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .frame_valid_i(frame_valid_i), .frame_abs_pos_i(frame_abs_pos_i), .frame_crc_i(frame_crc_i),
    .frame_busy_o(frame_busy_o), .frame_done_o(frame_done_o), .rd_i(rd_i), .rd_addr_i(rd_addr_i),
    .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .rmt_req_i(rmt_req_i), .rmt_if_i(rmt_if_i),
    .rmt_addr_i(rmt_addr_i), .rmt_ack_o(rmt_ack_o), .rmt_refuse_o(rmt_refuse_o),
    .rmt_rdata_o(rmt_rdata_o), .sm_req_o(sm_req_o), .sm_local_o(sm_local_o),
    .sm_addr_o(sm_addr_o), .sm_done_i(sm_done_i), .sm_rdata_i(sm_rdata_i));

/* sim/scp_safe_pos2_bank_test.sv */
/* Bench for the secondary position bank: reads, frames, remote window.
   Assumes the short-message model on the far side. */
`timescale 1ns/1ps
`include "scp_consts.vh"
module scp_safe_pos2_bank_test;
    // ====================
    // Stimulus and observed signals
    reg clk = 1'b0, rstn = 1'b0, fv = 1'b0, rd = 1'b0, rq = 1'b0, rwr = 1'b0, slow = 1'b0;
    reg [7:0] fst = 8'h00, rwd = 8'h00;
    reg [39:0] fpos = 40'h00_0000_0000;
    reg [15:0] fcrc = 16'h0000, e;
    reg [6:0] ra = 7'h00, qa = 7'h00;
    reg [1:0] qif = 2'h0;
    wire busy, done, cf, pf, tf, rv, ack, rf, smq, smw, smd;
    wire [7:0] rdat, qdat, smwd, smrd;
    wire [6:0] sma;
    integer bad_count = 0, n_compared = 0, i;
    localparam [39:0] P1 = 40'h12_3456_789a, P2 = 40'hff_0000_0001;
    // Remote cases: interface, address, refused
    localparam [159:0] RT = {16'h1400, 16'h0401, 16'h2401, 16'h0600, 16'h1671,
        16'h0681, 16'h17f0, 16'h13f1, 16'h05f1, 16'h1601};
    always #25 clk = ~clk;
    scp_safe_pos2_bank dut_u (.sys_clk_i(clk), .rstn_i(rstn), .frame_valid_i(fv),
        .frame_state_i(fst), .frame_abs_pos_i(fpos), .frame_crc_i(fcrc), .frame_busy_o(busy),
        .frame_done_o(done), .crc_fault_o(cf), .pattern_fault_o(pf), .toggle_fault_o(tf),
        .rd_i(rd), .rd_addr_i(ra), .rd_valid_o(rv), .rd_data_o(rdat), .rmt_req_i(rq),
        .rmt_if_i(qif), .rmt_addr_i(qa), .rmt_wr_i(rwr), .rmt_wdata_i(rwd), .rmt_ack_o(ack),
        .rmt_refuse_o(rf), .rmt_rdata_o(qdat), .sm_req_o(smq), .sm_local_o(), .sm_addr_o(sma),
        .sm_wr_o(smw), .sm_wdata_o(smwd), .sm_done_i(smd), .sm_rdata_i(smrd));
    scp_sm_engine sm_u (.sys_clk_i(clk), .rstn_i(rstn), .slow_i(slow), .sm_req_i(smq),
        .sm_addr_i(sma), .sm_wr_i(smw), .sm_wdata_i(smwd), .sm_done_o(smd), .sm_rdata_o(smrd));
    // ====================
    // Tasks
    task end_sim;
        begin
            $display("compared %0d mismatches %0d", n_compared, bad_count);
            if (bad_count == 0 && n_compared > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    task chk(input [39:0] got, input [39:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("ERROR %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    function [15:0] crc6(input [47:0] m);
        integer b;
        begin
            crc6 = 16'h0000;
            for (b = 47; b >= 0; b = b - 1)
                crc6 = {crc6[14:0], 1'b0} ^ ((crc6[15] ^ m[b]) ? 16'h90d9 : 16'h0000);
            crc6 = crc6 ^ 16'h00ff;
        end
    endfunction
    task rdchk(input [6:0] a, input [7:0] x);
        begin
            @(posedge clk);
            rd <= 1'b1;
            ra <= a;
            @(posedge clk);
            rd <= 1'b0;
            #1 chk(rv, 1'b1);
            chk(rdat, x);
        end
    endtask
    task regs(input [7:0] st, input [39:0] p, input [15:0] c);
        integer k;
        begin
            rdchk(`SCP_OFS_STATE, st);
            for (k = 0; k < 5; k = k + 1)
                rdchk(`SCP_OFS_POS4 + k[6:0], p[32 - 8 * k +: 8]);
            rdchk(`SCP_OFS_CRC_HI, c[15:8]);
            rdchk(`SCP_OFS_CRC_LO, c[7:0]);
        end
    endtask
    task frame(input [7:0] st, input [39:0] p, input [15:0] c, input [2:0] flt);
        begin
            @(posedge clk);
            fv <= 1'b1;
            fst <= st;
            fpos <= p;
            fcrc <= c;
            @(posedge clk);
            fv <= 1'b0;
            repeat (2) @(posedge clk);
            // A frame offered while busy must be dropped silently
            fv <= 1'b1;
            fst <= ~st;
            fpos <= ~p;
            @(posedge clk);
            fv <= 1'b0;
            repeat (3) @(posedge clk);
            #1 chk(done, 1'b0);
            @(posedge clk);
            #1 chk(done, 1'b1);
            chk({cf, pf, tf}, flt);
        end
    endtask
    task rmt(input [1:0] f, input [6:0] a, input w, input [7:0] d, input no, input dbl);
        integer n;
        begin
            @(posedge clk);
            rq <= 1'b1;
            qif <= f;
            qa <= a;
            rwr <= w;
            rwd <= d;
            @(posedge clk);
            rq <= dbl;
            qa <= a + 7'h01;
            #1 chk(rf, no);
            if (dbl) begin
                @(posedge clk);
                rq <= 1'b0;
                #1 chk(rf, 1'b1);
            end
            n = 0;
            while (!no && ack !== 1'b1 && n < 30) begin
                @(posedge clk);
                #1 n = n + 1;
            end
            if (!no && ack !== 1'b1) begin
                chk(ack, 1'b1);
                end_sim;
            end
            if (!no)
                chk(qdat, {1'b0, a} ^ 8'h5a);
        end
    endtask
    // ====================
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        for (i = 24; i < 33; i = i + 1)
            rdchk(i[6:0], 8'h00);
        $display("reset values test done");
        frame(8'h5c, P1, crc6({8'h5c, ~P1}), 3'h0);
        regs(8'h5c, ~P1, crc6({8'h5c, ~P1}));
        frame(8'hdc, P2, crc6({8'hdc, ~P2}) ^ 16'h0100, 3'h4);
        regs(8'hdc, ~P2, crc6({8'hdc, ~P2}) ^ 16'h0100);
        frame(8'he3, P1, crc6({8'he3, ~P1}), 3'h3);
        $display("frame test done");
        for (i = 0; i < 10; i = i + 1) begin
            e = RT[16 * i +: 16];
            slow <= i[0];
            rmt(e[13:12], e[10:4], 1'b0, 8'h00, e[0], 1'b0);
        end
        slow <= 1'b1;
        rmt(2'h1, 7'h41, 1'b1, 8'ha5, 1'b0, 1'b1);
        chk(sm_u.wd_q, 9'h1a5);
        $display("remote test done");
        @(posedge clk);
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        regs(8'h00, 40'h00_0000_0000, 16'h0000);
        frame(8'h1c, P2, crc6({8'h1c, ~P2}), 3'h0);
        $display("second reset test done");
        end_sim;
    end
endmodule // scp_safe_pos2_bank_test

/* sim/scp_sm_engine.sv */
/* Short-message engine model beside the remote window.
   Assumes the bank forwards at most one request at a time. */
`timescale 1ns/1ps
module scp_sm_engine (
    // Clock, reset and pace
    input wire sys_clk_i,
    input wire rstn_i,
    input wire slow_i,
    // Forwarded request
    input wire sm_req_i,
    input wire [6:0] sm_addr_i,
    input wire sm_wr_i,
    input wire [7:0] sm_wdata_i,
    // Answer
    output reg sm_done_o,
    output reg [7:0] sm_rdata_o
);
    // ====================
    // One transfer in flight
    reg busy_q;
    reg [3:0] cnt_q;
    reg [6:0] addr_q;
    reg [8:0] wd_q;
    always @(posedge sys_clk_i) begin
        sm_done_o <= 1'b0;
        // Data flips outside done so a stale value never passes
        sm_rdata_o <= ~sm_rdata_o;
        if (!rstn_i) begin
            busy_q <= 1'b0;
            sm_rdata_o <= 8'h00;
        end else if (sm_req_i && !busy_q) begin
            busy_q <= 1'b1;
            cnt_q <= slow_i ? 4'h6 : 4'h0;
            addr_q <= sm_addr_i;
            wd_q <= {sm_wr_i, sm_wdata_i};
        end else if (busy_q && cnt_q == 4'h0) begin
            busy_q <= 1'b0;
            sm_done_o <= 1'b1;
            sm_rdata_o <= {1'b0, addr_q} ^ 8'h5a;
        end else begin
            cnt_q <= cnt_q - 4'h1;
        end
    end
endmodule // scp_sm_engine
